// file: dcd_pkg.sv
/*
 * Shared constants for the two-channel converter control block.
 * Assumes a 40 MHz module clock and byte accesses on the peripheral bus.
 */
package dcd_pkg;
    // Register byte addresses
    localparam logic [31:0] DCD_ADDR_CH0 = 32'h040000A0;
    localparam logic [31:0] DCD_ADDR_CH1 = 32'h040000A2;
    localparam logic [31:0] DCD_ADDR_CTRL = 32'h040000A4;
    // Control register fields
    localparam int DCD_BIT_OE1 = 7;
    localparam int DCD_BIT_OE0 = 6;
    localparam int DCD_BIT_DAE = 5;
    localparam logic [4:0] DCD_CTRL_FIXED_ONES = 5'h1F;
    // Reset values
    localparam logic [7:0] DCD_RST_DATA = 8'h00;
    localparam logic [7:0] DCD_RST_CTRL = 8'h1F;
    // Conversion timing: longest time rounds down to whole cycles
    localparam int DCD_CLK_PERIOD_PS = 25000;
    localparam int DCD_CONV_TIME_NS = 10000;
    localparam int DCD_CONV_CYC = (DCD_CONV_TIME_NS * 1000) / DCD_CLK_PERIOD_PS;
    localparam int DCD_CNT_W = 9;
    // Channel sequencer phases
    typedef enum logic [1:0] {
        DCD_IDLE = 2'b00,
        DCD_CONV = 2'b01,
        DCD_HOLD = 2'b10
    } dcd_phase_t;
endpackage

// file: dcd_chan_if.sv
/*
 * Link between the register side and one conversion channel.
 * Assumes both ends run on the same module clock.
 */
`timescale 1ns/1ps
interface dcd_chan_if;
    logic [7:0] value;
    logic conv_en;
    logic standby;
    logic [7:0] level;
    logic settled;
    logic busy;
    modport ctrl (output value, output conv_en, output standby,
                  input level, input settled, input busy);
    modport conv (input value, input conv_en, input standby,
                  output level, output settled, output busy);
endinterface

// file: dcd_channel.sv
/*
 * One conversion channel: times a conversion of the data value and holds
 * the resulting level. Assumes control inputs are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module dcd_channel (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Link to the register side
    dcd_chan_if.conv ch
);
    typedef struct packed {
        dcd_pkg::dcd_phase_t phase;
        logic [dcd_pkg::DCD_CNT_W-1:0] cnt;
        logic [7:0] target;
        logic [7:0] level;
        logic settled;
    } dcd_chan_state_t;

    // Count includes the cycle that loads it, so the level lands within the limit
    localparam int CONV_LOAD_CYC = dcd_pkg::DCD_CONV_CYC - 1;
    localparam logic [dcd_pkg::DCD_CNT_W-1:0] CONV_LOAD =
        CONV_LOAD_CYC[dcd_pkg::DCD_CNT_W-1:0];

    dcd_chan_state_t st_ff;
    dcd_chan_state_t nxt_st;

    // Sequencer: restart on new data, freeze in standby, drop on disable
    always_comb
    begin
        nxt_st = st_ff;
        if (ch.standby)
        begin
            nxt_st = st_ff; // Output held during standby
        end
        else if (!ch.conv_en)
        begin
            nxt_st.phase = dcd_pkg::DCD_IDLE;
            nxt_st.settled = 1'b0; // Output released when disabled
        end
        else if (st_ff.phase == dcd_pkg::DCD_IDLE || ch.value != st_ff.target)
        begin
            nxt_st.phase = dcd_pkg::DCD_CONV; // Restart on new value
            nxt_st.target = ch.value;
            nxt_st.cnt = CONV_LOAD;
        end
        else if (st_ff.phase == dcd_pkg::DCD_CONV)
        begin
            if (st_ff.cnt == 1)
            begin
                nxt_st.phase = dcd_pkg::DCD_HOLD;
                nxt_st.level = st_ff.target; // Level is code over 256 of AVcc
                nxt_st.settled = 1'b1;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= '{dcd_pkg::DCD_IDLE, '0, 8'h00, 8'h00, 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Results toward the register side
    assign ch.level = st_ff.level;
    assign ch.settled = st_ff.settled;
    assign ch.busy = (st_ff.phase == dcd_pkg::DCD_CONV);

    localparam int CONV_MAX = dcd_pkg::DCD_CONV_CYC + 1;

    a_conv_done: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ch.conv_en && !ch.standby && ch.value != st_ff.target)
        |=> ##[1:CONV_MAX] (st_ff.settled || ch.standby || !ch.conv_en || ch.value != st_ff.target))
        else $error("conversion did not finish in time");
    a_level_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_ff.phase == dcd_pkg::DCD_CONV && st_ff.cnt == 1 && ch.conv_en && !ch.standby
         && ch.value == st_ff.target) |=> (st_ff.settled && ch.level == $past(st_ff.target)))
        else $error("converted level differs from data value");
    a_hold_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_ff.phase == dcd_pkg::DCD_HOLD && ch.conv_en && ch.value == st_ff.target)
        |=> ($stable(ch.level) && ch.settled))
        else $error("held level changed without new data");
    a_standby_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ch.standby |=> ($stable(ch.level) && $stable(ch.settled)))
        else $error("output moved during standby");
    c_conv_done: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(ch.settled));
    c_restart: cover property (@(posedge sys_clk) disable iff (!reset_n)
        ch.busy && ch.conv_en && ch.value != st_ff.target);
endmodule

// file: dcd_top.sv
/*
 * Register side of the two-channel converter control: two data registers,
 * one control register and the per-channel drive enables.
 * Assumes single-cycle byte accesses and inputs synchronous to sys_clk.
 */
// Notes on behaviour
// - Both data registers read and write, reset to zero, convert continuously when enabled.
// - Control register resets to 0x1F, with both enables and combining bit clear.
// - Control bit 7 enables channel 1 conversion and pin drive.
// - Control bit 6 enables channel 0 conversion and pin drive.
// - Bit 5 set lets either enable start both channels; clear keeps them independent.
// - Control bits 4 to 0 always read one; writes ignored.
// - Writing new data to an enabled channel restarts conversion; done within 10 us.
// - Driven level equals data value over 256 times the analogue reference.
// - Output holds until data changes or the channel enable clears.
// - Enable set drives the pin; enable clear releases it to input.
// - Entering standby while enabled keeps outputs held at last values.
`timescale 1ns/1ps
module dcd_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Peripheral byte bus
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [31:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_ack,
    // Power state
    input wire logic standby,
    // Channel 0 analogue output
    output logic [7:0] analog_out_ch0_level,
    output logic analog_out_ch0_valid,
    output logic analog_out_ch0_oe,
    // Channel 1 analogue output
    output logic [7:0] analog_out_ch1_level,
    output logic analog_out_ch1_valid,
    output logic analog_out_ch1_oe
);
    typedef struct packed {
        logic [7:0] ch0_val;
        logic [7:0] ch1_val;
        logic ch1_oe;
        logic ch0_oe;
        logic combine;
        logic [7:0] rdata;
        logic ack;
    } dcd_regs_t;

    dcd_regs_t st_ff;
    dcd_regs_t nxt_st;
    dcd_chan_if ch0_if ();
    dcd_chan_if ch1_if ();

    // Control register image as read back
    function automatic logic [7:0] ctrl_image(input dcd_regs_t s);
        ctrl_image = {s.ch1_oe, s.ch0_oe, s.combine, dcd_pkg::DCD_CTRL_FIXED_ONES};
    endfunction

    // Byte access decode, write and read data
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ack = bus_sel; // One-cycle answer
        nxt_st.rdata = 8'h00;
        if (bus_sel)
        begin
            case (bus_addr)
                dcd_pkg::DCD_ADDR_CH0:
                begin
                    nxt_st.rdata = st_ff.ch0_val;
                    if (bus_wr)
                    begin
                        nxt_st.ch0_val = bus_wdata;
                    end
                end
                dcd_pkg::DCD_ADDR_CH1:
                begin
                    nxt_st.rdata = st_ff.ch1_val;
                    if (bus_wr)
                    begin
                        nxt_st.ch1_val = bus_wdata;
                    end
                end
                dcd_pkg::DCD_ADDR_CTRL:
                begin
                    nxt_st.rdata = ctrl_image(st_ff); // Low bits fixed at one
                    if (bus_wr)
                    begin
                        nxt_st.ch1_oe = bus_wdata[dcd_pkg::DCD_BIT_OE1];
                        nxt_st.ch0_oe = bus_wdata[dcd_pkg::DCD_BIT_OE0];
                        nxt_st.combine = bus_wdata[dcd_pkg::DCD_BIT_DAE];
                    end
                end
                default:
                begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // Register file, reset to documented values
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff.ch0_val <= dcd_pkg::DCD_RST_DATA;
            st_ff.ch1_val <= dcd_pkg::DCD_RST_DATA;
            st_ff.ch1_oe <= dcd_pkg::DCD_RST_CTRL[dcd_pkg::DCD_BIT_OE1];
            st_ff.ch0_oe <= dcd_pkg::DCD_RST_CTRL[dcd_pkg::DCD_BIT_OE0];
            st_ff.combine <= dcd_pkg::DCD_RST_CTRL[dcd_pkg::DCD_BIT_DAE];
            st_ff.rdata <= 8'h00;
            st_ff.ack <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Conversion enable of one channel: its own bit, or the other bit when combined
    function automatic logic conv_enable(input logic own_oe, input logic other_oe,
        input logic comb);
        conv_enable = own_oe | (comb & other_oe);
    endfunction

    // Conversion enables, combined when the combining bit is set
    assign ch0_if.conv_en = conv_enable(st_ff.ch0_oe, st_ff.ch1_oe, st_ff.combine);
    assign ch1_if.conv_en = conv_enable(st_ff.ch1_oe, st_ff.ch0_oe, st_ff.combine);
    assign ch0_if.value = st_ff.ch0_val;
    assign ch1_if.value = st_ff.ch1_val;
    assign ch0_if.standby = standby;
    assign ch1_if.standby = standby;

    // Conversion channels
    dcd_channel u_ch0 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ch(ch0_if.conv)
    );
    dcd_channel u_ch1 (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ch(ch1_if.conv)
    );

    // Outputs straight from flip-flops
    assign bus_rdata = st_ff.rdata;
    assign bus_ack = st_ff.ack;
    assign analog_out_ch0_level = ch0_if.level;
    assign analog_out_ch1_level = ch1_if.level;
    assign analog_out_ch0_valid = ch0_if.settled;
    assign analog_out_ch1_valid = ch1_if.settled;
    assign analog_out_ch0_oe = st_ff.ch0_oe; // Pin driven only while enabled
    assign analog_out_ch1_oe = st_ff.ch1_oe;

    // Register writes, read back and drive enables
    a_data_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && bus_wr && bus_addr == dcd_pkg::DCD_ADDR_CH1)
        |=> (st_ff.ch1_val == $past(bus_wdata)))
        else $error("channel 1 data write lost");
    a_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && !bus_wr && bus_addr == dcd_pkg::DCD_ADDR_CTRL)
        |=> (bus_ack && bus_rdata[4:0] == 5'h1F
             && bus_rdata[7] == analog_out_ch1_oe && bus_rdata[6] == analog_out_ch0_oe))
        else $error("control read back wrong");
    a_oe1_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && bus_wr && bus_addr == dcd_pkg::DCD_ADDR_CTRL)
        |=> (analog_out_ch1_oe == $past(bus_wdata[7])))
        else $error("channel 1 drive enable not taken");
    a_oe0_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && bus_wr && bus_addr == dcd_pkg::DCD_ADDR_CTRL)
        |=> (analog_out_ch0_oe == $past(bus_wdata[6])))
        else $error("channel 0 drive enable not taken");
    a_combine_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!standby && !st_ff.ch0_oe && !(st_ff.combine && st_ff.ch1_oe))
        |=> !analog_out_ch0_valid)
        else $error("channel 0 converting while disabled");
    a_pin_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && bus_wr && bus_addr == dcd_pkg::DCD_ADDR_CTRL && !bus_wdata[6])
        |=> !analog_out_ch0_oe)
        else $error("channel 0 pin still driven");
    a_bus_answer: assert property (@(posedge sys_clk) disable iff (!reset_n)
        bus_sel |=> bus_ack ##1 (bus_ack == $past(bus_sel)))
        else $error("bus access not answered in one cycle");
    a_ch0_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && bus_wr && bus_addr == dcd_pkg::DCD_ADDR_CH0)
        |=> (st_ff.ch0_val == $past(bus_wdata)))
        else $error("channel 0 data write lost");
    a_ch0_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && !bus_wr && bus_addr == dcd_pkg::DCD_ADDR_CH0)
        |=> (bus_ack && bus_rdata == st_ff.ch0_val))
        else $error("channel 0 data read back wrong");
    a_ch1_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!standby && !st_ff.ch1_oe && !(st_ff.combine && st_ff.ch0_oe))
        |=> !analog_out_ch1_valid)
        else $error("channel 1 converting while disabled");
    a_combine_on: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (st_ff.combine && (st_ff.ch0_oe || st_ff.ch1_oe))
        |-> (ch0_if.conv_en && ch1_if.conv_en))
        else $error("combining bit did not enable both channels");
    a_pin1_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && bus_wr && bus_addr == dcd_pkg::DCD_ADDR_CTRL && !bus_wdata[7])
        |=> !analog_out_ch1_oe)
        else $error("channel 1 pin still driven");
    // Bus answers outside the three registers
    a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (bus_sel && bus_addr != dcd_pkg::DCD_ADDR_CH0 && bus_addr != dcd_pkg::DCD_ADDR_CH1
         && bus_addr != dcd_pkg::DCD_ADDR_CTRL) |=> (bus_ack && bus_rdata == 8'h00))
        else $error("unmapped address returned data");
    a_bus_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !bus_sel |=> (!bus_ack && bus_rdata == 8'h00))
        else $error("bus answered without a request");
    // Scenario covers
    c_both_on: cover property (@(posedge sys_clk) disable iff (!reset_n)
        analog_out_ch0_valid && analog_out_ch1_valid);
    c_combined: cover property (@(posedge sys_clk) disable iff (!reset_n)
        st_ff.combine && st_ff.ch0_oe && !st_ff.ch1_oe && analog_out_ch1_valid);
    c_standby_held: cover property (@(posedge sys_clk) disable iff (!reset_n)
        standby && analog_out_ch0_valid);
endmodule

// file: dcd_pin_model.sv
/*
 * Behavioural model of the analogue pins fed by the converter control.
 * Assumes levels and enables are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module dcd_pin_model (
    // Clock
    input wire logic sys_clk,
    // Channel 0 drive
    input wire logic [7:0] level0,
    input wire logic valid0,
    input wire logic oe0,
    // Channel 1 drive
    input wire logic [7:0] level1,
    input wire logic valid1,
    input wire logic oe1,
    // Pin view
    output logic [7:0] pin0,
    output logic [7:0] pin1,
    output logic drv0,
    output logic drv1
);
    logic [7:0] hold0 = 8'h00;
    logic [7:0] hold1 = 8'h00;
    // Remember last driven code so a released pin shows its inverse
    always @(posedge sys_clk)
    begin
        if (oe0) hold0 <= level0;
        if (oe1) hold1 <= level1;
    end
    // Pin carries code/256 of the reference only while driven
    assign pin0 = (oe0 && valid0) ? level0 : ~hold0;
    assign pin1 = (oe1 && valid1) ? level1 : ~hold1;
    assign drv0 = oe0;
    assign drv1 = oe1;
endmodule

// file: dual_channel_dac_control_bench.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the pin model and a 25 ns module clock.
 */
`timescale 1ns/1ps
module dual_channel_dac_control_bench;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic bus_sel = 1'b0;
    logic bus_wr = 1'b0;
    logic [31:0] bus_addr = 32'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic standby = 1'b0;
    logic [7:0] bus_rdata, l0, l1, p0, p1, q, d0, d1;
    logic bus_ack, v0, v1, o0, o1, dr0, dr1, e0, e1;
    logic [31:0] seed = 32'h0CB9;
    int n_fail = 0;
    int checks_done = 0;
    dcd_top dcd_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .bus_sel(bus_sel),
        .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .standby(standby), .analog_out_ch0_level(l0),
        .analog_out_ch0_valid(v0), .analog_out_ch0_oe(o0), .analog_out_ch1_level(l1),
        .analog_out_ch1_valid(v1), .analog_out_ch1_oe(o1));
    dcd_pin_model dcd_pin_model_inst (.sys_clk(sys_clk), .level0(l0), .valid0(v0), .oe0(o0),
        .level1(l1), .valid1(v1), .oe1(o1), .pin0(p0), .pin1(p1), .drv0(dr0), .drv1(dr1));
    // Module clock
    always #12.5 sys_clk = ~sys_clk;
    // Repeatable random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One byte access, waits a bounded time for the acknowledge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
        int n;
        @(negedge sys_clk);
        bus_sel = 1'b1;
        bus_wr = wr;
        bus_addr = a;
        bus_wdata = d;
        @(negedge sys_clk);
        bus_sel = 1'b0;
        n = 0;
        while (bus_ack !== 1'b1 && n < 3)
        begin
            @(negedge sys_clk);
            n++;
        end
        q = bus_rdata;
        check("ack", {7'h0, bus_ack}, 8'h01);
    endtask
    // Wait for both channels to reach the expected state, then compare
    task automatic settle(input int lim);
        int n;
        n = 0;
        while (n < lim && !(v0 === e0 && v1 === e1 && (!e0 || l0 === d0) && (!e1 || l1 === d1)))
        begin
            @(negedge sys_clk);
            n++;
        end
        check("valid0", {7'h0, v0}, {7'h0, e0});
        check("valid1", {7'h0, v1}, {7'h0, e1});
        if (e0) check("level0", l0, d0);
        if (e1) check("level1", l1, d1);
    endtask
    // Verdict
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #(25 * 20000);
        n_fail++;
        end_sim();
    end
    // Main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        bus(1'b0, dcd_pkg::DCD_ADDR_CH0, 8'h00);
        check("ch0 reset", q, 8'h00);
        bus(1'b0, dcd_pkg::DCD_ADDR_CH1, 8'h00);
        check("ch1 reset", q, 8'h00);
        bus(1'b0, dcd_pkg::DCD_ADDR_CTRL, 8'h00);
        check("ctrl reset", q, 8'h1F);
        check("oe reset", {6'h0, o1, o0}, 8'h00);
        bus(1'b1, 32'h040000A6, 8'hFF);
        bus(1'b0, 32'h040000A6, 8'h00);
        check("unmapped", q, 8'h00);
        // Every enable combination with random data and reserved bits
        for (int k = 0; k < 8; k++)
        begin
            seed = xs(seed);
            d0 = seed[7:0];
            d1 = seed[15:8];
            bus(1'b1, dcd_pkg::DCD_ADDR_CH0, d0);
            bus(1'b1, dcd_pkg::DCD_ADDR_CH1, d1);
            bus(1'b1, dcd_pkg::DCD_ADDR_CTRL, {k[2:0], seed[20:16]});
            e0 = k[1] | (k[0] & k[2]);
            e1 = k[2] | (k[0] & k[1]);
            bus(1'b0, dcd_pkg::DCD_ADDR_CTRL, 8'h00);
            check("ctrl read", q, {k[2:0], 5'h1F});
            check("oe pins", {6'h0, o1, o0}, {6'h0, k[2:1]});
            check("drive", {6'h0, dr1, dr0}, {6'h0, k[2:1]});
            settle(400);
            bus(1'b0, dcd_pkg::DCD_ADDR_CH0, 8'h00);
            check("ch0 read", q, d0);
            if (k[1]) check("pin0", p0, d0);
            bus(1'b0, dcd_pkg::DCD_ADDR_CH1, 8'h00);
            check("ch1 read", q, d1);
            if (k[2]) check("pin1", p1, d1);
        end
        // New data mid-run keeps the old result until the new one lands
        d0 = ~d0;
        bus(1'b1, dcd_pkg::DCD_ADDR_CH0, d0);
        repeat (100) @(negedge sys_clk);
        check("held", l0, ~d0);
        repeat (dcd_pkg::DCD_CONV_CYC - 100) @(negedge sys_clk);
        check("in time", l0, d0);
        settle(400);
        // Standby while enabled freezes the outputs
        standby = 1'b1;
        bus(1'b1, dcd_pkg::DCD_ADDR_CH1, ~d1);
        repeat (420) @(negedge sys_clk);
        check("standby", l1, d1);
        check("standby valid", {7'h0, v1}, 8'h01);
        standby = 1'b0;
        d1 = ~d1;
        settle(402);
        // Enables cleared before standby, as software should
        bus(1'b1, dcd_pkg::DCD_ADDR_CTRL, 8'h00);
        repeat (2) @(negedge sys_clk);
        check("off", {4'h0, v1, v0, dr1, dr0}, 8'h00);
        standby = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("off standby", {4'h0, v1, v0, dr1, dr0}, 8'h00);
        standby = 1'b0;
        // Reset in mid-run returns channel 0 data and the control register to their initial values
        bus(1'b1, dcd_pkg::DCD_ADDR_CH0, 8'h5A);
        bus(1'b1, dcd_pkg::DCD_ADDR_CTRL, 8'hE0);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        check("oe after reset", {4'h0, v1, v0, o1, o0}, 8'h00);
        bus(1'b0, dcd_pkg::DCD_ADDR_CH0, 8'h00);
        check("ch0 after reset", q, 8'h00);
        bus(1'b0, dcd_pkg::DCD_ADDR_CTRL, 8'h00);
        check("ctrl after reset", q, 8'h1F);
        end_sim();
    end
endmodule
